// [rtl/osce_top.sv]
// oscillator source enable logic with apb register access
//
// Overview of operation
// - primary mode from four-bit configuration field
// - software bit enables primary when allowed
// - primary kept running while system clock
// - crystal gain low, intermediate, highest by mode
// - rc mode uses input pin, output configurable
// - output pin clock is oscillator over four
// - external clock low, medium, high power
// - internal mode frees input pin, output optional
// - secondary oscillator follows its enable bit
// - low oscillator clocks timers and monitor
// - low oscillator enabled by timer conditions
// - low oscillator enabled for low path
// - eight postscaled frequencies, 1 MHz default
// - low path select picks 31 kHz source
// - high oscillator enabled by select conditions
// - read-only flag shows high oscillator stable
// - frequency select code decoding
// - clock select field decoding
// - primary drive bit resets to one
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module osce_top (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic [osce_pkg::APB_AW-1:0]   paddr,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [osce_pkg::APB_DW-1:0]   pwdata,
    output logic                               pready,
    output logic      [osce_pkg::APB_DW-1:0]   prdata,
    output logic                               pslverr,
    input  wire logic [3:0]                    config_mode_field,
    input  wire logic                          primary_sw_control_cfg,
    input  wire logic                          powerup_timer_disable_n,
    input  wire logic                          watchdog_cfg_enable,
    input  wire logic                          failsafe_monitor_enable,
    input  wire logic                          two_speed_start_enable,
    input  wire logic                          crystal_in_pin,
    input  wire logic                          secondary_osc_in,
    input  wire logic                          lf_osc_in,
    input  wire logic                          hf_osc_in,
    input  wire logic                          hf_osc_ready,
    input  wire logic                          gpio_out_data,
    input  wire logic                          gpio_out_oe_n,
    output logic                               primary_osc_enable,
    output logic      [1:0]                    crystal_gain,
    output logic      [1:0]                    ec_power,
    output logic                               secondary_osc_run,
    output logic                               lf_osc_enable,
    output logic                               hf_osc_enable,
    output logic                               lf_timer_tick,
    output logic                               crystal_in_is_io,
    output logic                               crystal_out_o,
    output logic                               crystal_out_oe_n,
    output logic                               crystal_out_is_clock
);
    import osce_pkg::*;

    // registers
    logic [2:0]            internal_freq_select;
    logic [1:0]            clock_select_field;
    logic                  primary_drive_on;
    logic                  low_freq_path_select;
    logic [5:0]            tune_value;
    logic                  secondary_osc_enable;
    logic                  watchdog_sw_enable;
    logic [PS_W-1:0]       ps_cnt;
    logic [1:0]            div_cnt;

    // synchronised oscillator inputs
    logic [SYNC_W-1:0]     sync_level;
    logic [SYNC_W-1:0]     sync_rise;

    osce_sync u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({hf_osc_ready, hf_osc_in, lf_osc_in, secondary_osc_in, crystal_in_pin}),
        .level    (sync_level),
        .rise     (sync_rise)
    );

    // apb decode
    wire              setup_phase = psel & ~penable;
    wire              access      = psel & penable;
    wire              hit_ctrl    = (paddr == ADDR_CTRL);
    wire              hit_ctrl2   = (paddr == ADDR_CTRL2);
    wire              hit_tune    = (paddr == ADDR_TUNE);
    wire              hit_t1      = (paddr == ADDR_TIMER1_CONTROL_REG);
    wire              hit_aux     = (paddr == ADDR_AUX);
    wire              hit_stat    = (paddr == ADDR_STAT);
    wire              hit_any     = hit_ctrl | hit_ctrl2 | hit_tune | hit_t1 | hit_aux | hit_stat;
    wire              wr_en       = access & pwrite & hit_any;

    assign pready  = 1'b1;
    assign pslverr = access & ~hit_any;

    // mode decode
    wire              mode_int    = osce_is_internal(config_mode_field);
    wire              mode_cko    = osce_has_divided_clock_out(config_mode_field);
    wire              scs_int     = clock_select_field[SCS_INT_BIT];
    wire              scs_sec     = (clock_select_field == SCS_SECONDARY);
    wire              scs_pri     = (clock_select_field == SCS_PRIMARY);
    wire              low_path    = (internal_freq_select == IFS_31K) & ~low_freq_path_select;
    wire              hf_path     = ~low_path;
    wire              hf_stable   = hf_osc_enable & sync_level[SYN_HFRDY];

    // oscillator enables
    wire next_primary_en = ~primary_sw_control_cfg | primary_drive_on | scs_pri;
    wire next_lf_en      = ~powerup_timer_disable_n | watchdog_cfg_enable
                         | (~watchdog_cfg_enable & watchdog_sw_enable)
                         | failsafe_monitor_enable;
    wire next_lf_path_en = low_path & (scs_int | mode_int | two_speed_start_enable);
    wire next_hf_en      = hf_path & (scs_int | mode_int | two_speed_start_enable
                         | failsafe_monitor_enable);

    // postscaler on the 16 MHz source; division 1 ticks on every source edge
    wire [PS_W-1:0] ps_last   = osce_ps_div(internal_freq_select) - 10'h001;
    wire            ps_tick   = sync_rise[SYN_HF] & hf_osc_enable & (ps_cnt >= ps_last);
    wire            lf_tick   = sync_rise[SYN_LF] & lf_osc_enable;
    wire            int_tick  = low_path ? lf_tick : ps_tick;
    wire            pri_tick  = mode_int ? int_tick : (sync_rise[SYN_XIN] & primary_osc_enable);
    wire            sec_tick  = sync_rise[SYN_SOSC] & secondary_osc_run;
    wire            sel_tick  = scs_int ? int_tick : (scs_sec ? sec_tick : pri_tick);

    wire [PS_W-1:0] next_ps_cnt = (ps_tick || ps_cnt > ps_last) ? '0
                                : (sync_rise[SYN_HF] ? ps_cnt + 10'h001 : ps_cnt);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ps_cnt  <= '0;
            div_cnt <= 2'h0;
        end else begin
            ps_cnt <= next_ps_cnt;
            if (sel_tick) begin
                div_cnt <= div_cnt + 2'h1;
            end
        end
    end

    // register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            internal_freq_select <= IFS_RST;
            clock_select_field   <= SCS_RST;
        end else if (wr_en && hit_ctrl) begin
            internal_freq_select <= pwdata[CTRL_IFS_LSB +: 3];
            clock_select_field   <= pwdata[CTRL_SCS_LSB +: 2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primary_drive_on <= PDO_RST;
        end else if (wr_en && hit_ctrl2) begin
            primary_drive_on <= pwdata[CTRL2_PDO_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_freq_path_select <= LFPS_RST;
            tune_value           <= TUN_RST;
        end else if (wr_en && hit_tune) begin
            low_freq_path_select <= pwdata[TUNE_LFPS_BIT];
            tune_value           <= pwdata[TUNE_TUN_LSB +: 6];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            secondary_osc_enable <= 1'b0;
            watchdog_sw_enable   <= 1'b0;
        end else begin
            if (wr_en && hit_t1) begin
                secondary_osc_enable <= pwdata[T1_SOSC_BIT];
            end
            if (wr_en && hit_aux) begin
                watchdog_sw_enable <= pwdata[AUX_WDT_SW_BIT];
            end
        end
    end

    // read mux, captured in the setup phase so prdata is a flop
    logic [APB_DW-1:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        if (hit_ctrl) begin
            rd_mux[CTRL_IFS_LSB +: 3]  = internal_freq_select;
            rd_mux[CTRL_STABLE_BIT]    = hf_stable;
            rd_mux[CTRL_SCS_LSB +: 2]  = clock_select_field;
        end
        if (hit_ctrl2) begin
            rd_mux[CTRL2_PDO_BIT] = primary_drive_on;
        end
        if (hit_tune) begin
            rd_mux[TUNE_LFPS_BIT]      = low_freq_path_select;
            rd_mux[TUNE_TUN_LSB +: 6]  = tune_value;
        end
        if (hit_t1) begin
            rd_mux[T1_SOSC_BIT] = secondary_osc_enable;
        end
        if (hit_aux) begin
            rd_mux[AUX_WDT_SW_BIT] = watchdog_sw_enable;
        end
        if (hit_stat) begin
            rd_mux[STAT_PRI_BIT] = primary_osc_enable;
            rd_mux[STAT_SEC_BIT] = secondary_osc_run;
            rd_mux[STAT_LF_BIT]  = lf_osc_enable;
            rd_mux[STAT_HF_BIT]  = hf_osc_enable;
            rd_mux[STAT_CKO_BIT] = crystal_out_is_clock;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup_phase && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primary_osc_enable   <= 1'b1;
            crystal_gain         <= LVL_OFF;
            ec_power             <= LVL_OFF;
            secondary_osc_run    <= 1'b0;
            lf_osc_enable        <= 1'b0;
            hf_osc_enable        <= 1'b0;
            lf_timer_tick        <= 1'b0;
            crystal_in_is_io     <= 1'b0;
            crystal_out_is_clock <= 1'b0;
            crystal_out_o        <= 1'b0;
            crystal_out_oe_n     <= 1'b1;
        end else begin
            primary_osc_enable   <= next_primary_en;
            crystal_gain         <= next_primary_en ? osce_gain(config_mode_field) : LVL_OFF;
            ec_power             <= next_primary_en ? osce_ec_power(config_mode_field) : LVL_OFF;
            secondary_osc_run    <= secondary_osc_enable;
            lf_osc_enable        <= next_lf_en | next_lf_path_en;
            hf_osc_enable        <= next_hf_en;
            lf_timer_tick        <= lf_tick;
            crystal_in_is_io     <= mode_int;
            crystal_out_is_clock <= mode_cko;
            // clock mode drives the pin; io mode passes port logic through
            crystal_out_o        <= mode_cko ? div_cnt[1] : gpio_out_data;
            crystal_out_oe_n     <= mode_cko ? 1'b0 : gpio_out_oe_n;
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_t1_write_on;
        wr_en && hit_t1 && pwdata[T1_SOSC_BIT];
    endsequence
    AST_PRI_HELD: assert property (scs_pri |=> primary_osc_enable)
        else $error("primary oscillator stopped while it is the system clock");
    AST_PRI_SW_OFF: assert property (primary_sw_control_cfg && !primary_drive_on && !scs_pri
                                     |=> !primary_osc_enable)
        else $error("primary oscillator not shut down by software");
    AST_GAIN_LP: assert property (config_mode_field == MODE_LP && next_primary_en
                                  |=> crystal_gain == LVL_LOW)
        else $error("low power crystal mode gives wrong gain");
    AST_EC_MED: assert property (config_mode_field == MODE_ECM_IO && next_primary_en
                                 |=> ec_power == LVL_MID)
        else $error("external clock medium power not selected");
    AST_SOSC_ON: assert property (s_t1_write_on |=> ##1 secondary_osc_run)
        else $error("secondary oscillator did not follow its enable");
    AST_LF_FSCM: assert property (failsafe_monitor_enable |=> lf_osc_enable)
        else $error("low oscillator off with fail-safe monitor enabled");
    AST_LF_PATH: assert property (low_path && scs_int |=> lf_osc_enable && !hf_osc_enable)
        else $error("31 kHz path not taken from low oscillator");
    AST_HF_SEL: assert property (scs_int && internal_freq_select != IFS_31K |=> hf_osc_enable)
        else $error("high oscillator off while selected");
    // checks the flag through the read flop, not just the wire that feeds it
    AST_STABLE: assert property (setup_phase && !pwrite && hit_ctrl
                                 && !(hf_osc_enable && sync_level[SYN_HFRDY]) |=> !prdata[CTRL_STABLE_BIT])
        else $error("stable flag read high while high oscillator off or not ready");
    AST_CKO_QUARTER: assert property ($changed(div_cnt[1]) |-> $past(sel_tick) && $past(div_cnt[0]))
        else $error("divided clock output toggled off the quarter count");
    AST_CKO_PIN: assert property (mode_cko && !$changed(config_mode_field)
                                  |=> !crystal_out_oe_n && crystal_out_o == $past(div_cnt[1]))
        else $error("crystal output pin not carrying the divided clock");

endmodule : osce_top

// [rtl/osce_pkg.sv]
// constants, encodings and decode functions for the oscillator source enable block
package osce_pkg;

    localparam int unsigned APB_AW = 8;
    localparam int unsigned APB_DW = 32;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_CTRL2 = 8'h04;
    localparam logic [7:0] ADDR_TUNE  = 8'h08;
    localparam logic [7:0] ADDR_TIMER1_CONTROL_REG = 8'h0C;
    localparam logic [7:0] ADDR_AUX   = 8'h10;
    localparam logic [7:0] ADDR_STAT  = 8'h14;

    // field positions
    localparam int unsigned CTRL_IFS_LSB    = 4;
    localparam int unsigned CTRL_STABLE_BIT = 2;
    localparam int unsigned CTRL_SCS_LSB    = 0;
    localparam int unsigned CTRL2_PDO_BIT   = 2;
    localparam int unsigned TUNE_LFPS_BIT   = 7;
    localparam int unsigned TUNE_TUN_LSB    = 0;
    localparam int unsigned T1_SOSC_BIT     = 0;
    localparam int unsigned AUX_WDT_SW_BIT  = 0;
    localparam int unsigned STAT_PRI_BIT    = 0;
    localparam int unsigned STAT_SEC_BIT    = 1;
    localparam int unsigned STAT_LF_BIT     = 2;
    localparam int unsigned STAT_HF_BIT     = 3;
    localparam int unsigned STAT_CKO_BIT    = 4;

    // reset values
    localparam logic [2:0] IFS_RST  = 3'h3;
    localparam logic [1:0] SCS_RST  = 2'h0;
    localparam logic       PDO_RST  = 1'b1;
    localparam logic       LFPS_RST = 1'b0;
    localparam logic [5:0] TUN_RST  = 6'h00;

    // internal frequency select codes
    localparam logic [2:0] IFS_31K  = 3'h0;
    localparam logic [2:0] IFS_250K = 3'h1;
    localparam logic [2:0] IFS_500K = 3'h2;
    localparam logic [2:0] IFS_1M   = 3'h3;
    localparam logic [2:0] IFS_2M   = 3'h4;
    localparam logic [2:0] IFS_4M   = 3'h5;
    localparam logic [2:0] IFS_8M   = 3'h6;
    localparam logic [2:0] IFS_16M  = 3'h7;

    // clock select field
    localparam logic [1:0] SCS_PRIMARY   = 2'h0;
    localparam logic [1:0] SCS_SECONDARY = 2'h1;
    localparam int unsigned SCS_INT_BIT  = 1;

    // primary oscillator mode field
    localparam logic [3:0] MODE_LP         = 4'h0;
    localparam logic [3:0] MODE_XT         = 4'h1;
    localparam logic [3:0] MODE_HS         = 4'h2;
    localparam logic [3:0] MODE_RC_DIVIDED_CLOCK_OUT  = 4'h3;
    localparam logic [3:0] MODE_RC_IO      = 4'h4;
    localparam logic [3:0] MODE_ECH_DIVIDED_CLOCK_OUT = 4'h5;
    localparam logic [3:0] MODE_ECH_IO     = 4'h6;
    localparam logic [3:0] MODE_ECM_DIVIDED_CLOCK_OUT = 4'h7;
    localparam logic [3:0] MODE_ECM_IO     = 4'h8;
    localparam logic [3:0] MODE_ECL_DIVIDED_CLOCK_OUT = 4'h9;
    localparam logic [3:0] MODE_ECL_IO     = 4'hA;
    localparam logic [3:0] MODE_INT_IO     = 4'hB;
    localparam logic [3:0] MODE_INT_DIVIDED_CLOCK_OUT = 4'hC;

    // amplifier gain and external clock power levels
    localparam logic [1:0] LVL_OFF  = 2'h0;
    localparam logic [1:0] LVL_LOW  = 2'h1;
    localparam logic [1:0] LVL_MID  = 2'h2;
    localparam logic [1:0] LVL_HIGH = 2'h3;

    // synchroniser lanes
    localparam int unsigned SYNC_W    = 5;
    localparam int unsigned SYN_XIN   = 0;
    localparam int unsigned SYN_SOSC  = 1;
    localparam int unsigned SYN_LF    = 2;
    localparam int unsigned SYN_HF    = 3;
    localparam int unsigned SYN_HFRDY = 4;

    localparam int unsigned PS_W = 10;

    // postscaler division of the 16 MHz source, in source edges per tick
    function automatic logic [PS_W-1:0] osce_ps_div(input logic [2:0] ifs);
        case (ifs)
            IFS_16M:  osce_ps_div = 10'h001;
            IFS_8M:   osce_ps_div = 10'h002;
            IFS_4M:   osce_ps_div = 10'h004;
            IFS_2M:   osce_ps_div = 10'h008;
            IFS_1M:   osce_ps_div = 10'h010;
            IFS_500K: osce_ps_div = 10'h020;
            IFS_250K: osce_ps_div = 10'h040;
            default:  osce_ps_div = 10'h200;
        endcase
    endfunction : osce_ps_div

    function automatic logic osce_is_internal(input logic [3:0] m);
        osce_is_internal = (m == MODE_INT_IO) || (m == MODE_INT_DIVIDED_CLOCK_OUT);
    endfunction : osce_is_internal

    function automatic logic osce_has_divided_clock_out(input logic [3:0] m);
        osce_has_divided_clock_out = (m == MODE_RC_DIVIDED_CLOCK_OUT) || (m == MODE_ECH_DIVIDED_CLOCK_OUT) || (m == MODE_ECM_DIVIDED_CLOCK_OUT)
                          || (m == MODE_ECL_DIVIDED_CLOCK_OUT) || (m == MODE_INT_DIVIDED_CLOCK_OUT);
    endfunction : osce_has_divided_clock_out

    function automatic logic [1:0] osce_gain(input logic [3:0] m);
        case (m)
            MODE_LP: osce_gain = LVL_LOW;
            MODE_XT: osce_gain = LVL_MID;
            MODE_HS: osce_gain = LVL_HIGH;
            default: osce_gain = LVL_OFF;
        endcase
    endfunction : osce_gain

    function automatic logic [1:0] osce_ec_power(input logic [3:0] m);
        case (m)
            MODE_ECL_DIVIDED_CLOCK_OUT, MODE_ECL_IO: osce_ec_power = LVL_LOW;
            MODE_ECM_DIVIDED_CLOCK_OUT, MODE_ECM_IO: osce_ec_power = LVL_MID;
            MODE_ECH_DIVIDED_CLOCK_OUT, MODE_ECH_IO: osce_ec_power = LVL_HIGH;
            default:                      osce_ec_power = LVL_OFF;
        endcase
    endfunction : osce_ec_power

endpackage : osce_pkg

// [rtl/osce_sync.sv]
// three-stage synchronisers with agreement filter and rising-edge pulse
`timescale 1ns/1ps
module osce_sync (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic [osce_pkg::SYNC_W-1:0]  async_in,
    output logic      [osce_pkg::SYNC_W-1:0]  level,
    output logic      [osce_pkg::SYNC_W-1:0]  rise
);
    import osce_pkg::*;

    logic [SYNC_W-1:0] stg1;
    logic [SYNC_W-1:0] stg2;
    logic [SYNC_W-1:0] stg3;
    logic [SYNC_W-1:0] agree;

    genvar g;
    generate
        for (g = 0; g < SYNC_W; g++) begin : g_lane
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stg1[g] <= 1'b0;
                    stg2[g] <= 1'b0;
                    stg3[g] <= 1'b0;
                end else begin
                    stg1[g] <= async_in[g];
                    stg2[g] <= stg1[g];
                    stg3[g] <= stg2[g];
                end
            end
            // stage one feeds only stage two
            assign agree[g] = (stg2[g] == stg3[g]);
            assign rise[g]  = agree[g] & stg2[g] & ~level[g];
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    level[g] <= 1'b0;
                end else if (agree[g]) begin
                    level[g] <= stg2[g];
                end
            end
        end
    endgenerate

endmodule : osce_sync

// [tb/osce_osc_model.sv]
// behavioural external oscillator standing on the far side of the source pins
`timescale 1ns/1ps
module osce_osc_model #(
    parameter int HALF = 8
) (
    input  wire logic pclk,
    input  wire logic en,
    output logic      osc_o
);
    int cnt = 0;
    initial osc_o = 1'b0;
    // a stopped oscillator parks low, so a dead source never looks like a live edge
    always @(posedge pclk) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (!en) osc_o <= 1'b0;
        else if (cnt == HALF - 1) osc_o <= ~osc_o;
    end
endmodule : osce_osc_model

// [tb/testbench.sv]
// self-checking bench for the oscillator source enable block
`timescale 1ns/1ps
module testbench;
    import osce_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, r;
    logic [3:0]  config_mode_field = 4'h0;
    logic        primary_sw_control_cfg = 0, powerup_timer_disable_n = 1, watchdog_cfg_enable = 0;
    logic        failsafe_monitor_enable = 0, two_speed_start_enable = 0, hf_osc_ready = 1;
    logic        gpio_out_data = 0, gpio_out_oe_n = 1, pready, pslverr, err, hf, lf, low, intl, p_in, p_out;
    logic        crystal_in_pin, secondary_osc_in, lf_osc_in, hf_osc_in, primary_osc_enable;
    logic        secondary_osc_run, lf_osc_enable, hf_osc_enable, lf_timer_tick, crystal_in_is_io;
    logic        crystal_out_o, crystal_out_oe_n, crystal_out_is_clock, p_lf, cko, pe, src;
    logic [1:0]  crystal_gain, ec_power;
    int          n_fail = 0, cmp_count = 0, nin, nout, nlf, ntk, md;
    always #2.5 pclk = ~pclk;
    osce_top uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata, .pslverr,
        .config_mode_field, .primary_sw_control_cfg, .powerup_timer_disable_n, .watchdog_cfg_enable,
        .failsafe_monitor_enable, .two_speed_start_enable, .crystal_in_pin, .secondary_osc_in, .lf_osc_in,
        .hf_osc_in, .hf_osc_ready, .gpio_out_data, .gpio_out_oe_n, .primary_osc_enable, .crystal_gain,
        .ec_power, .secondary_osc_run, .lf_osc_enable, .hf_osc_enable, .lf_timer_tick, .crystal_in_is_io,
        .crystal_out_o, .crystal_out_oe_n, .crystal_out_is_clock);
    osce_osc_model #(.HALF(8))  m_pri (.pclk, .en(primary_osc_enable), .osc_o(crystal_in_pin));
    osce_osc_model #(.HALF(40)) m_sec (.pclk, .en(secondary_osc_run), .osc_o(secondary_osc_in));
    osce_osc_model #(.HALF(20)) m_lf  (.pclk, .en(lf_osc_enable), .osc_o(lf_osc_in));
    osce_osc_model #(.HALF(8))  m_hf  (.pclk, .en(hf_osc_enable), .osc_o(hf_osc_in));
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : chk
    // request held until pready is sampled high; read data taken at that same edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    initial begin
        #100us;
        n_fail++;
        complete_run;
    end
    initial begin
        void'($urandom(32'h6f78));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, ADDR_CTRL, 0);
        chk("ctrl reset", rd, 32'h30);
        apb(0, ADDR_CTRL2, 0);
        chk("ctrl2 reset", rd, 32'h4);
        apb(0, 8'h18, 0);
        chk("unmapped error", err, 1);
        chk("unmapped data", rd, 0);
        for (int m = 0; m <= 12; m++) begin
            @(posedge pclk);
            config_mode_field <= m[3:0];
            repeat (4) @(posedge pclk);
            chk("gain", crystal_gain, m < 3 ? m + 1 : 0);
            chk("ec power", ec_power, (m >= 5 && m <= 10) ? 3 - (m - 5) / 2 : 0);
            chk("out clock", crystal_out_is_clock, m == 3 || m == 12 || (m >= 5 && m <= 9 && m % 2));
            chk("in io", crystal_in_is_io, m == 11 || m == 12);
        end
        $display("mode test done");
        for (int it = 0; it < 40; it++) begin
            r = $urandom;
            @(posedge pclk);
            {config_mode_field, primary_sw_control_cfg, powerup_timer_disable_n, watchdog_cfg_enable,
             failsafe_monitor_enable, two_speed_start_enable, gpio_out_data, gpio_out_oe_n, hf_osc_ready}
                <= {4'(r % 13), r[9:3], r[19]};
            apb(1, ADDR_CTRL, {25'h0, r[12:10], 2'b00, r[14:13]});
            apb(1, ADDR_CTRL2, {29'h0, r[15], 2'b00});
            apb(1, ADDR_TUNE, {24'h0, r[16], 7'h0});
            apb(1, ADDR_TIMER1_CONTROL_REG, {31'h0, r[17]});
            apb(1, ADDR_AUX, {31'h0, r[18]});
            repeat (8) @(posedge pclk);
            md = r % 13;
            intl = md >= 11;
            cko = md == 3 || md == 12 || (md >= 5 && md <= 9 && md % 2 == 1);
            pe = !r[9] || r[15] || r[14:13] == 2'h0;
            low = r[12:10] == 3'h0 && !r[16];
            hf = (r[14] || intl || r[5] || r[6]) && !low;
            lf = !r[8] || r[7] || r[18] || r[6] || (low && (r[14] || intl || r[5]));
            chk("primary en", primary_osc_enable, pe);
            chk("pin enable", crystal_out_oe_n, cko ? 1'b0 : r[3]);
            if (!cko) chk("pin data", crystal_out_o, r[4]);
            chk("secondary en", secondary_osc_run, r[17]);
            chk("lf en", lf_osc_enable, lf);
            chk("hf en", hf_osc_enable, hf);
            apb(0, ADDR_CTRL, 0);
            chk("ctrl read", rd, {25'h0, r[12:10], 1'b0, hf && r[19], r[14:13]});
            apb(0, ADDR_STAT, 0);
            chk("status read", rd, {27'h0, cko, hf, lf, r[17], pe});
        end
        $display("enable test done");
        // k: primary pin, internal high path, secondary oscillator
        for (int k = 0; k < 3; k++) begin
            @(posedge pclk);
            {config_mode_field, primary_sw_control_cfg, powerup_timer_disable_n}
                <= {k == 1 ? MODE_INT_DIVIDED_CLOCK_OUT : MODE_RC_DIVIDED_CLOCK_OUT, 2'b00};
            apb(1, ADDR_TIMER1_CONTROL_REG, 32'h1);
            apb(1, ADDR_CTRL, k == 1 ? 32'h70 : (k == 2 ? 32'h31 : 32'h30));
            repeat (40) @(negedge pclk);
            nin = 0;
            nout = 0;
            nlf = 0;
            ntk = 0;
            // start high so a stale previous sample never counts as an edge
            p_in = 1'b1;
            p_out = 1'b1;
            p_lf = 1'b1;
            repeat (1024) begin
                @(negedge pclk);
                src = k == 2 ? secondary_osc_in : (k == 1 ? hf_osc_in : crystal_in_pin);
                nin += int'(src && !p_in);
                nout += int'(crystal_out_o && !p_out);
                nlf += int'(lf_osc_in && !p_lf);
                ntk += int'(lf_timer_tick);
                p_in = src;
                p_out = crystal_out_o;
                p_lf = lf_osc_in;
            end
            chk("source ran", nin > (k == 2 ? 8 : 32), 1);
            chk("lf ticks", nlf > 8 && ntk >= nlf - 2 && ntk <= nlf + 2, 1);
            chk("quarter rate", nout * 4 >= nin - 4 && nout * 4 <= nin + 4, 1);
        end
        $display("clock out test done");
        complete_run;
    end
endmodule : testbench
